/* File: hdl/conv_clock_prescaler.v */
// divider chain: oscillator to machine clock to conversion clock enable
`default_nettype none
module conv_clock_prescaler (
    input  wire       i_clk_sys,
    input  wire       i_rstn,
    input  wire [1:0] i_sys_clock_divider,
    input  wire [3:0] i_conv_clock_prescale,
    output reg        o_mclk_en,
    output reg        o_aclk_en
);
`include "sar_adc_consts.vh"
    reg  [10:0] osc_cnt_reg;
    reg  [3:0]  pre_cnt_reg;
    reg  [10:0] osc_ratio;
    // divider code select, code 00 is the 4-period default
    always @* begin
        case (i_sys_clock_divider)
            2'h0:    osc_ratio = `MCLK_DIV_4;     // R13 R14
            2'h1:    osc_ratio = `MCLK_DIV_64;    // R13
            default: osc_ratio = `MCLK_DIV_1024;  // R13
        endcase
    end
    // machine clock enable from oscillator periods
    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            osc_cnt_reg <= 11'h000;
            o_mclk_en   <= 1'b0;
        end else if (osc_cnt_reg >= osc_ratio - 11'h001) begin
            osc_cnt_reg <= 11'h000;
            o_mclk_en   <= 1'b1;                   // R13
        end else begin
            osc_cnt_reg <= osc_cnt_reg + 11'h001;
            o_mclk_en   <= 1'b0;
        end
    end
    // conversion clock every prescale+1 machine clocks; >= guards a shrunk prescale
    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            pre_cnt_reg <= 4'h0;
            o_aclk_en   <= 1'b0;
        end else begin
            o_aclk_en <= 1'b0;
            if (o_mclk_en) begin
                if (pre_cnt_reg >= i_conv_clock_prescale) begin
                    pre_cnt_reg <= 4'h0;
                    o_aclk_en   <= 1'b1;           // R8 R11 R12 R19
                end else begin
                    pre_cnt_reg <= pre_cnt_reg + 4'h1;
                end
            end
        end
    end
endmodule // conv_clock_prescaler
`default_nettype wire

/* File: hdl/sar_adc_consts.vh */
// constants and register map for the sar converter sequencer
// Summary of operation
// (R1) result is ten bits wide, giving 1024 codes across the reference range
// (R2) code equals 1024*(vin-ref_low_node)/(ref_high_node-ref_low_node), set by comparator decisions
// (R3) a conversion begins only on an internal start pulse to the sar logic
// (R4) one trial bit per conversion clock, bit 9 first, bit 0 last
// (R5) keep trial bit set when comparator says dac below sampled input
// (R6) clear trial bit when comparator says dac above sampled input
// (R7) after all bits decided the approximation register holds the result
// (R8) conversion clock is divided down from the machine clock
// (R9) a conversion takes exactly 16 conversion clocks
// (R10) software keeps conversion clock period between 1 and 6.25 us
// (R11) four-bit prescale field selects one of sixteen conversion clock rates
// (R12) conversion clock period is machine clock period times prescale plus one
// (R13) machine clock period is 4, 64 or 1024 oscillator periods by divider bits
// (R14) machine clock defaults to 4 oscillator periods after reset
// (R15) sample-hold samples during the first five conversion clocks
// (R16) ten conversion clocks perform the bit decisions
// (R17) done flag set on the last conversion clock of a conversion
// (R18) reset clears converter power-on, converter stays powered down
// (R19) prescaler counter yields one conversion clock per prescale+1 machine clocks
// (R20) approximation register keeps last result between conversions
`ifndef SAR_ADC_CONSTS_VH
`define SAR_ADC_CONSTS_VH
// register offsets
`define ADDR_CONTROL       4'h0
`define ADDR_CONVERTER_CTL2 4'h1
`define ADDR_POWER_MGMT    4'h2
`define ADDR_RESULT        4'h3
`define ADDR_STATUS        4'h4
// control register fields
`define CTL_START_BIT      0
`define CTL_DONE_BIT       1
`define CTL_POWER_BIT      2
// power management fields
`define POWER_MGMT_DIV_LO_BIT 0
`define POWER_MGMT_DIV_HI_BIT 1
// reset values
`define CTL_RESET          8'h00
`define CTL2_RESET         8'h00
`define POWER_MGMT_RESET   8'h00
// machine clock ratios for divider codes
`define MCLK_DIV_4         11'h004
`define MCLK_DIV_64        11'h040
`define MCLK_DIV_1024      11'h400
// conversion timing in conversion clocks
`define CONV_TOTAL_CLKS    5'h10
`define CONV_SAMPLE_CLKS   5'h05
`define CONV_SAR_CLKS      5'h0A
`endif

/* File: hdl/sar_adc_sequencer.v */
// sar converter sequencer with prescaler and register port
//
// The register offsets and the address-and-strobe port were decided locally.
`default_nettype none
module sar_adc_sequencer #(
    parameter RES_BITS = 10
) (
    input  wire                i_clk_sys,
    input  wire                i_rstn,
    input  wire [3:0]          i_addr,
    input  wire [7:0]          i_wdata,
    input  wire                i_wr,
    input  wire                i_rd,
    output reg  [7:0]          o_rdata,
    input  wire                i_comp_dac_below,
    output reg  [RES_BITS-1:0] o_dac_code,
    output reg                 o_sample,
    output reg                 o_converter_power_on,
    output reg                 o_conv_done,
    output reg                 o_busy
);
`include "sar_adc_consts.vh"
    localparam ST_IDLE   = 2'h0;
    localparam ST_SAMPLE = 2'h1;
    localparam ST_SAR    = 2'h2;
    localparam ST_FINISH = 2'h3;
    // index of the first trial bit, sized to the bit counter
    localparam [3:0] MSB_IDX = RES_BITS - 1;

    reg  [1:0]          state_reg;
    reg  [4:0]          clk_cnt_reg;
    reg  [3:0]          bit_idx_reg;
    reg  [RES_BITS-1:0] trial_reg;
    reg  [RES_BITS-1:0] approx_register;
    reg  [3:0]          conv_clock_prescale;
    reg  [1:0]          sys_clock_divider;
    reg                 start_pulse;
    wire                mclk_en;
    wire                aclk_en;
    wire                wr_ctl;

    assign wr_ctl = i_wr && (i_addr == `ADDR_CONTROL);

    // divider chain lives in its own module
    conv_clock_prescaler u_prescaler (
        .i_clk_sys             (i_clk_sys),
        .i_rstn                (i_rstn),
        .i_sys_clock_divider   (sys_clock_divider),
        .i_conv_clock_prescale (conv_clock_prescale),
        .o_mclk_en             (mclk_en),
        .o_aclk_en             (aclk_en)
    );

    // configuration registers; power-on and divider cleared by reset
    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            conv_clock_prescale  <= 4'h0;
            sys_clock_divider    <= 2'h0;          // R14
            o_converter_power_on <= 1'b0;          // R18
        end else if (i_wr) begin
            if (i_addr == `ADDR_CONVERTER_CTL2)
                conv_clock_prescale <= i_wdata[3:0];  // R11
            if (i_addr == `ADDR_POWER_MGMT)
                sys_clock_divider <= {i_wdata[`POWER_MGMT_DIV_HI_BIT], i_wdata[`POWER_MGMT_DIV_LO_BIT]};  // R13
            if (wr_ctl)
                o_converter_power_on <= i_wdata[`CTL_POWER_BIT];
        end
    end

    // internal start pulse: software start while idle and powered
    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            start_pulse <= 1'b0;
        end else if (wr_ctl && i_wdata[`CTL_START_BIT] && o_converter_power_on
                     && state_reg == ST_IDLE && !start_pulse) begin
            start_pulse <= 1'b1;                   // R3
        end else if (aclk_en || !o_converter_power_on) begin
            start_pulse <= 1'b0;                   // consumed on next conversion clock
        end
    end

    // sequencer: 5 sample + 10 decision + 1 finish clocks = 16
    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg       <= ST_IDLE;
            clk_cnt_reg     <= 5'h00;
            bit_idx_reg     <= 4'h0;
            trial_reg       <= {RES_BITS{1'b0}};
            approx_register <= {RES_BITS{1'b0}};
            o_dac_code      <= {RES_BITS{1'b0}};
            o_sample        <= 1'b0;
            o_busy          <= 1'b0;
        end else if (!o_converter_power_on) begin
            // power-down is the only way to abort a conversion
            state_reg  <= ST_IDLE;
            o_sample   <= 1'b0;
            o_busy     <= 1'b0;
        end else if (aclk_en) begin
            case (state_reg)
                ST_IDLE: begin
                    if (start_pulse) begin         // R3
                        state_reg   <= ST_SAMPLE;
                        clk_cnt_reg <= 5'h01;
                        o_sample    <= 1'b1;       // R15
                        o_busy      <= 1'b1;
                    end
                end
                ST_SAMPLE: begin
                    if (clk_cnt_reg == `CONV_SAMPLE_CLKS) begin  // R15
                        state_reg   <= ST_SAR;
                        o_sample    <= 1'b0;
                        bit_idx_reg <= MSB_IDX;                  // R4
                        trial_reg   <= {1'b1, {(RES_BITS-1){1'b0}}};
                        o_dac_code  <= {1'b1, {(RES_BITS-1){1'b0}}};
                    end
                    clk_cnt_reg <= clk_cnt_reg + 5'h01;
                end
                ST_SAR: begin
                    // decide current bit, then set the next trial bit
                    clk_cnt_reg <= clk_cnt_reg + 5'h01;
                    if (i_comp_dac_below)
                        trial_reg <= trial_reg;                  // R5
                    else
                        trial_reg[bit_idx_reg] <= 1'b0;          // R6
                    if (bit_idx_reg == 4'h0) begin               // R4 R16
                        state_reg <= ST_FINISH;
                        o_dac_code[0] <= i_comp_dac_below;
                        approx_register <= {trial_reg[RES_BITS-1:1], i_comp_dac_below};  // R7 R1 R2
                    end else begin
                        bit_idx_reg <= bit_idx_reg - 4'h1;
                        o_dac_code <= (i_comp_dac_below ? trial_reg : (trial_reg & ~({{(RES_BITS-1){1'b0}},1'b1}
                                      << bit_idx_reg))) | ({{(RES_BITS-1){1'b0}},1'b1} << (bit_idx_reg - 4'h1));
                        trial_reg[bit_idx_reg - 4'h1] <= 1'b1;   // R4
                    end
                end
                ST_FINISH: begin
                    // sixteenth clock: finish and drop busy
                    state_reg <= ST_IDLE;                        // R9
                    o_busy    <= 1'b0;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // done flag: set on last conversion clock, software clears; set wins
    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_conv_done <= 1'b0;
        end else if (aclk_en && o_converter_power_on && state_reg == ST_FINISH) begin
            o_conv_done <= 1'b1;                   // R17 R9
        end else if (wr_ctl && !i_wdata[`CTL_DONE_BIT]) begin
            o_conv_done <= 1'b0;
        end
    end

    // read port, data one cycle after the strobe; unmapped reads zero
    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                `ADDR_CONTROL:        o_rdata <= {5'h00, o_converter_power_on, o_conv_done, o_busy};
                `ADDR_CONVERTER_CTL2: o_rdata <= {4'h0, conv_clock_prescale};
                `ADDR_POWER_MGMT:     o_rdata <= {6'h00, sys_clock_divider};
                `ADDR_RESULT:         o_rdata <= approx_register[RES_BITS-1:2];  // R20
                `ADDR_STATUS:         o_rdata <= {6'h00, approx_register[1:0]};  // R20
                default:              o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end
endmodule // sar_adc_sequencer
`default_nettype wire

/* File: verif/analog_front_model.sv */
// behavioural sample-hold, dac and comparator
`default_nettype none
module analog_front_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_sample,
    input  wire logic [9:0] i_vin,
    input  wire logic [9:0] i_dac_code,
    output logic            o_comp_dac_below
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] held_reg = 10'h000;
    // track the input while sampling, freeze it for the decisions
    always @(posedge i_clk_sys) begin
        if (i_sample) held_reg <= i_vin;
    end
    // half-lsb offset so an equal code is kept
    assign o_comp_dac_below = {i_dac_code, 1'b0} < {held_reg, 1'b1};
endmodule // analog_front_model
`default_nettype wire

/* File: verif/sar_adc_monitor.sv */
// port checker for the sar converter sequencer
`default_nettype none
module sar_adc_monitor #(
    parameter RES_BITS = 10
) (
    input wire logic                i_clk_sys,
    input wire logic                i_rstn,
    input wire logic [3:0]          i_addr,
    input wire logic [7:0]          i_wdata,
    input wire logic                i_wr,
    input wire logic                i_rd,
    input wire logic [7:0]          o_rdata,
    input wire logic [RES_BITS-1:0] o_dac_code,
    input wire logic                o_sample,
    input wire logic                o_converter_power_on,
    input wire logic                o_conv_done,
    input wire logic                o_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0]  ps_reg;
    logic [1:0]  dv_reg;
    logic [19:0] bcnt_reg;
    logic [19:0] scnt_reg;
    logic [19:0] per;
    // shadow of the clock settings; lengths are only valid if unchanged mid-run
    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            ps_reg <= 4'h0;
            dv_reg <= 2'h0;
            bcnt_reg <= 20'h00000;
            scnt_reg <= 20'h00000;
        end else begin
            if (i_wr && i_addr == 4'h1) ps_reg <= i_wdata[3:0];
            if (i_wr && i_addr == 4'h2) dv_reg <= i_wdata[1:0];
            bcnt_reg <= o_busy ? bcnt_reg + 20'h00001 : 20'h00000;
            scnt_reg <= o_sample ? scnt_reg + 20'h00001 : 20'h00000;
        end
    end
    // conversion clock period in system cycles
    assign per = (dv_reg == 2'h0 ? 20'h00004 : (dv_reg == 2'h1 ? 20'h00040 : 20'h00400)) * ({16'h0000, ps_reg} + 20'h00001);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    sequence conv_begin; o_sample ##0 o_converter_power_on; endsequence
    sequence conv_end; !o_busy ##0 o_conv_done; endsequence
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("read data outside slot");
    a_busy_begin: assert property ($rose(o_busy) |-> conv_begin) else $error("bad conversion start");
    a_sample_busy: assert property (o_sample |-> o_busy) else $error("sample outside conversion");
    a_done_end: assert property ($fell(o_busy) |-> conv_end) else $error("done missing at end");
    a_conv_length: assert property ($fell(o_busy) |-> bcnt_reg == per * 20'h00010) else $error("bad length");
    a_sample_len: assert property ($fell(o_sample) |-> scnt_reg == per * 20'h00005) else $error("bad sample");
    a_msb_first: assert property ($fell(o_sample) |-> o_dac_code == 10'h200) else $error("first trial not msb");
    a_done_clear: assert property (i_wr && i_addr == 4'h0 && !i_wdata[1] && !o_busy |=> !o_conv_done)
        else $error("done not cleared");
    a_power_wr: assert property (i_wr && i_addr == 4'h0 |=> o_converter_power_on == $past(i_wdata[2]))
        else $error("power bit wrong");
endmodule // sar_adc_monitor
`default_nettype wire

/* File: verif/sar_adc_sequencer_prescaler_test.sv */
// testbench for the sar converter sequencer
`default_nettype none
module sar_adc_sequencer_prescaler_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic       i_clk_sys = 1'b0;
    logic       i_rstn = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic       i_wr = 1'b0;
    logic       i_rd = 1'b0;
    logic [9:0] vin = 10'h000;
    logic [9:0] last_res = 10'h000;
    wire  [7:0] o_rdata;
    wire  [9:0] o_dac_code;
    wire        i_comp_dac_below, o_sample, o_converter_power_on, o_conv_done, o_busy;
    int         n_fail = 0;
    int         checks = 0;
    always #12.5 i_clk_sys = ~i_clk_sys;
    sar_adc_sequencer dut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_comp_dac_below(i_comp_dac_below),
        .o_dac_code(o_dac_code), .o_sample(o_sample), .o_converter_power_on(o_converter_power_on),
        .o_conv_done(o_conv_done), .o_busy(o_busy));
    analog_front_model afe (.i_clk_sys(i_clk_sys), .i_sample(o_sample), .i_vin(vin),
        .i_dac_code(o_dac_code), .o_comp_dac_below(i_comp_dac_below));
    task automatic complete_run;
        if (n_fail == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic t_reset_state;
        logic [7:0] d;
        logic [3:0] al[4] = '{4'h0, 4'h1, 4'h2, 4'hF};
        foreach (al[i]) begin
            rd(al[i], d);
            check("reset read", 20'h00000, {12'h000, d});
        end
    endtask
    task automatic t_start_unpowered;
        wr(4'h0, 8'h01);
        repeat (40) @(posedge i_clk_sys);
        #1 check("busy unpowered", 20'h00000, {19'h00000, o_busy});
    endtask
    // slow divider codes are only read back: any conversion on them breaks the period window
    task automatic t_divider_codes;
        logic [7:0] d;
        wr(4'h2, 8'h02);
        rd(4'h2, d);
        check("divider code", 20'h00002, {12'h000, d});
        wr(4'h2, 8'h03);
        rd(4'h2, d);
        check("divider code", 20'h00003, {12'h000, d});
    endtask
    task automatic t_convert(input logic [9:0] v, input logic [3:0] ps, input logic [1:0] dv);
        logic [7:0] d;
        logic [7:0] e;
        int n;
        int bn;
        int ratio;
        ratio = dv == 2'h0 ? 4 : (dv == 2'h1 ? 64 : 1024);
        bn = 0;
        wr(4'h1, {4'h0, ps});
        vin <= v;
        wr(4'h2, {6'h00, dv});
        wr(4'h0, 8'h04);
        wr(4'h0, 8'h05);
        for (n = 0; n < 60000 && o_conv_done !== 1'b1; n++) begin
            @(posedge i_clk_sys);
            #1;
            if (o_busy === 1'b1) bn++;
            if (bn == 8) begin
                rd(4'h3, d);
                bn += 2;
                check("result mid run", {12'h000, last_res[9:2]}, {12'h000, d});
            end
        end
        if (n == 60000) begin
            n_fail++;
            complete_run();
        end
        check("busy cycles", 16 * ratio * (ps + 1), bn);
        rd(4'h3, d);
        rd(4'h4, e);
        check("result", {10'h000, v}, {10'h000, d, e[1:0]});
        rd(4'h0, d);
        check("status done", 20'h00006, {17'h00000, d[2:0]});
        wr(4'h0, 8'h04);
        rd(4'h0, d);
        check("status cleared", 20'h00004, {17'h00000, d[2:0]});
        last_res = v;
    endtask
    initial begin
        repeat (5) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        t_reset_state();
        t_start_unpowered();
        t_divider_codes();
        // settings keep the conversion clock between 1.1 and 4.8 us at 25 ns
        t_convert(10'h2AA, 4'hA, 2'h0);
        t_convert(10'h3FF, 4'hF, 2'h0);
        t_convert(10'h000, 4'h1, 2'h1);
        t_convert(10'h155, 4'h0, 2'h1);
        t_convert(10'h001, 4'h2, 2'h1);
        complete_run();
    end
endmodule // sar_adc_sequencer_prescaler_test
bind sar_adc_sequencer sar_adc_monitor #(.RES_BITS(RES_BITS)) mon (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_dac_code(o_dac_code),
    .o_sample(o_sample), .o_converter_power_on(o_converter_power_on), .o_conv_done(o_conv_done), .o_busy(o_busy));
`default_nettype wire
